// ===== rtl/dsp_top.sv
// debug controller: access gating by mode/security, and stop-mode clock handshake
// assumes serial-interface clock ticks arrive as an asynchronous toggle-free pulse level,
// synchronised here, as is the clock-source select; all other inputs are on clk
`timescale 1ns/1ps
module dsp_top (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// mode and security, sampled at reset release
	input wire dsp_pkg::dsp_mode_type mode,
	input wire logic secured,
	// debug settings
	input wire logic debug_enable_bit,
	input wire logic debug_clocks_in_stop_bit,
	input wire logic debug_clock_source_select,
	// serial-interface clock, from the link side
	input wire logic debug_serial_interface_clock,
	// host command
	input wire logic cmd_valid,
	input wire dsp_pkg::dsp_cmd_type cmd,
	output logic cmd_accept,
	output logic cmd_reject,
	// internal access progress
	input wire logic debug_access_busy,
	// stop control
	input wire logic stop_request,
	input wire logic wake_request,
	input wire logic bus_masters_idle,
	output logic stop_active,
	output logic stop_handshake_busy,
	// clock gates
	output dsp_pkg::dsp_clk_gate_type clk_gate,
	// status
	output logic active_debug_state,
	output logic controller_enabled,
	output logic debug_clock_ok
);
	import dsp_pkg::*;

	// ************************
	// mode and security capture
	// ************************
	logic reset_seen;
	logic special_mode;
	logic secured_latched;
	logic enable_eff;

	// mode straps caught on the first clock after release, not by reset itself
	always_ff @(posedge clk) begin
		if (reset) begin
			reset_seen <= 1'b0;
			special_mode <= 1'b0;
			secured_latched <= 1'b1;
		end else if (!reset_seen) begin
			reset_seen <= 1'b1;
			special_mode <= (mode == DSP_MODE_SPECIAL_SINGLE);
			secured_latched <= secured;
		end
	end

	// ************************
	// controller enable and active state
	// ************************
	logic next_controller_enabled;

	always_comb begin
		next_controller_enabled = controller_enabled;
		if (!reset_seen) begin
			next_controller_enabled = 1'b0;
		end else if (!special_mode && secured_latched) begin
			next_controller_enabled = 1'b0;
		end else if (special_mode) begin
			next_controller_enabled = 1'b1;
		end else if (!stop_active) begin
			next_controller_enabled = debug_enable_bit;
		end else begin
			// serial clock is dead in stop when disabled, so no enabling there
			next_controller_enabled = controller_enabled;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			controller_enabled <= 1'b0;
		end else begin
			controller_enabled <= next_controller_enabled;
		end
	end

	// active debug state straight out of reset in special single-chip mode
	always_ff @(posedge clk) begin
		if (reset) begin
			active_debug_state <= 1'b0;
		end else if (!reset_seen) begin
			active_debug_state <= (mode == DSP_MODE_SPECIAL_SINGLE);
		end else if (!next_controller_enabled) begin
			active_debug_state <= 1'b0;
		end
	end

	assign enable_eff = controller_enabled;

	// ************************
	// command gating
	// ************************
	logic cmd_allowed;

	dsp_cmd_filter u_filter (
		.controller_enabled(enable_eff),
		.secured(secured_latched),
		.cmd(cmd),
		.allowed(cmd_allowed)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_accept <= 1'b0;
			cmd_reject <= 1'b0;
		end else begin
			cmd_accept <= cmd_valid && cmd_allowed;
			cmd_reject <= cmd_valid && !cmd_allowed;
		end
	end

	// ************************
	// serial clock tick detection
	// ************************
	logic si_sync;
	logic si_prev;
	logic si_tick;

	dsp_sync u_si_sync (
		.clk(clk),
		.reset(reset),
		.async_in(debug_serial_interface_clock),
		.sync_out(si_sync)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			si_prev <= 1'b0;
		end else begin
			si_prev <= si_sync;
		end
	end

	assign si_tick = si_sync && !si_prev;

	// ************************
	// clock source select
	// ************************
	logic css_sync;

	// select comes from the host side, so it is resynchronised like the serial clock
	dsp_sync u_css_sync (
		.clk(clk),
		.reset(reset),
		.async_in(debug_clock_source_select),
		.sync_out(css_sync)
	);

	// debug clock usable across stop only with source select clear
	always_ff @(posedge clk) begin
		if (reset) begin
			debug_clock_ok <= 1'b0;
		end else begin
			debug_clock_ok <= !css_sync;
		end
	end

	// ************************
	// stop handshake
	// ************************
	dsp_stop_state_type state;
	dsp_stop_state_type next_state;
	logic [1:0] si_count;
	logic [1:0] bus_count;
	logic ack_done;
	logic count_clear;

	assign ack_done = (si_count == DSP_ACK_SI_CYCLES) && (bus_count == DSP_ACK_BUS_CYCLES);

	always_comb begin
		next_state = state;
		count_clear = 1'b0;
		case (state)
			DSP_ST_RUN: begin
				if (stop_request) begin
					next_state = DSP_ST_ENTER_WAIT;
				end
			end
			DSP_ST_ENTER_WAIT: begin
				// pending: clocks untouched until masters and debug access finish
				if (bus_masters_idle && !debug_access_busy) begin
					count_clear = 1'b1;
					next_state = enable_eff ? DSP_ST_ENTER_ACK : DSP_ST_STOPPED;
				end
			end
			DSP_ST_ENTER_ACK: begin
				if (ack_done) begin
					next_state = DSP_ST_STOPPED;
				end
			end
			DSP_ST_STOPPED: begin
				if (wake_request) begin
					count_clear = 1'b1;
					next_state = enable_eff ? DSP_ST_EXIT_ACK : DSP_ST_RUN;
				end
			end
			DSP_ST_EXIT_ACK: begin
				if (ack_done) begin
					next_state = DSP_ST_RUN;
				end
			end
			default: next_state = DSP_ST_RUN;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= DSP_ST_RUN;
		end else begin
			state <= next_state;
		end
	end

	// serial ticks counted first, then bus cycles
	always_ff @(posedge clk) begin
		if (reset || count_clear) begin
			si_count <= '0;
			bus_count <= '0;
		end else if (state == DSP_ST_ENTER_ACK || state == DSP_ST_EXIT_ACK) begin
			if (si_count != DSP_ACK_SI_CYCLES) begin
				if (si_tick) begin
					si_count <= si_count + 2'h1;
				end
			end else if (bus_count != DSP_ACK_BUS_CYCLES) begin
				bus_count <= bus_count + 2'h1;
			end
		end
	end

	// ************************
	// outputs
	// ************************
	dsp_clk_gate_type next_gate;

	// exit handshake keeps the stop clocking and the stopped flag until it completes
	function automatic logic held_in_stop(input dsp_stop_state_type s);
		return (s == DSP_ST_STOPPED) || (s == DSP_ST_EXIT_ACK);
	endfunction

	always_comb begin
		next_gate = '{bus_clk_en: 1'b1, si_clk_en: 1'b1, core_clk_en: 1'b1};
		if (held_in_stop(state)) begin
			if (!enable_eff) begin
				next_gate = '{bus_clk_en: 1'b0, si_clk_en: 1'b0, core_clk_en: 1'b0};
			end else if (!debug_clocks_in_stop_bit) begin
				next_gate = '{bus_clk_en: 1'b0, si_clk_en: 1'b1, core_clk_en: 1'b1};
			end else begin
				next_gate = '{bus_clk_en: 1'b1, si_clk_en: 1'b1, core_clk_en: 1'b1};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			clk_gate <= '{bus_clk_en: 1'b1, si_clk_en: 1'b1, core_clk_en: 1'b1};
		end else begin
			clk_gate <= next_gate;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stop_active <= 1'b0;
		end else begin
			stop_active <= held_in_stop(next_state);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			stop_handshake_busy <= 1'b0;
		end else begin
			stop_handshake_busy <= (next_state == DSP_ST_ENTER_WAIT) || (next_state == DSP_ST_ENTER_ACK)
				|| (next_state == DSP_ST_EXIT_ACK);
		end
	end
endmodule // dsp_top

// ===== rtl/dsp_pkg.sv
// shared types and constants for the debug port stop/security block
// assumes a single 40 MHz bus clock; serial-interface clock arrives as an asynchronous level, synchronised in dsp_top
package dsp_pkg;

	// ************************
	// operating modes
	// ************************
	typedef enum logic [1:0] {
		DSP_MODE_NORMAL_SINGLE = 2'b00,
		DSP_MODE_NORMAL_EXP = 2'b01,
		DSP_MODE_SPECIAL_SINGLE = 2'b10,
		DSP_MODE_SPECIAL_TEST = 2'b11
	} dsp_mode_type;

	// ************************
	// command classes
	// ************************
	typedef enum logic [1:0] {
		DSP_CMD_ALWAYS = 2'b00,
		DSP_CMD_ACTIVE_ONLY = 2'b01,
		DSP_CMD_MEMORY = 2'b10,
		DSP_CMD_MASS_ERASE = 2'b11
	} dsp_cmd_class_type;

	typedef struct packed {
		dsp_cmd_class_type cmd_class;
		logic [7:0] opcode;
	} dsp_cmd_type;

	// ************************
	// stop handshake
	// ************************
	typedef enum logic [2:0] {
		DSP_ST_RUN = 3'b000,
		DSP_ST_ENTER_WAIT = 3'b001,
		DSP_ST_ENTER_ACK = 3'b010,
		DSP_ST_STOPPED = 3'b011,
		DSP_ST_EXIT_ACK = 3'b100
	} dsp_stop_state_type;

	localparam logic [1:0] DSP_ACK_SI_CYCLES = 2'h2;
	localparam logic [1:0] DSP_ACK_BUS_CYCLES = 2'h2;

	typedef struct packed {
		logic bus_clk_en;
		logic si_clk_en;
		logic core_clk_en;
	} dsp_clk_gate_type;

endpackage

// ===== rtl/dsp_sync.sv
// two-flop synchroniser for one level from outside the clock domain
// assumes clk is the bus clock
`timescale 1ns/1ps
module dsp_sync (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// level
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;

	always_ff @(posedge clk) begin
		if (reset) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // dsp_sync

// ===== rtl/dsp_cmd_filter.sv
// decides whether a host debug command may run, from controller enable and security
// assumes mode and security are stable outside reset
`timescale 1ns/1ps
module dsp_cmd_filter (
	// state
	input wire logic controller_enabled,
	input wire logic secured,
	// command
	input wire dsp_pkg::dsp_cmd_type cmd,
	output logic allowed
);
	import dsp_pkg::*;

	always_comb begin
		allowed = 1'b0;
		if (controller_enabled) begin
			if (!secured) begin
				allowed = 1'b1;
			end else begin
				// secure: only always-available, plus mass erase for unlocking
				case (cmd.cmd_class)
					DSP_CMD_ALWAYS: allowed = 1'b1;
					DSP_CMD_MASS_ERASE: allowed = 1'b1;
					DSP_CMD_MEMORY: allowed = 1'b0;
					default: allowed = 1'b0;
				endcase
			end
		end
	end
endmodule // dsp_cmd_filter

// ===== tb/dsp_top_properties.sv
// checker on the ports of dsp_top
// assumes mode, secured and stop settings are held steady by the bench
`timescale 1ns/1ps
module dsp_top_chk (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// settings
	input wire logic secured,
	input wire logic debug_clocks_in_stop_bit,
	input wire logic controller_enabled,
	// commands
	input wire logic cmd_valid,
	input wire dsp_pkg::dsp_cmd_type cmd,
	input wire logic cmd_accept,
	input wire logic cmd_reject,
	// stop
	input wire logic debug_access_busy,
	input wire logic bus_masters_idle,
	input wire logic wake_request,
	input wire logic stop_active,
	input wire logic stop_handshake_busy,
	input wire dsp_pkg::dsp_clk_gate_type clk_gate
);
	import dsp_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_off; cmd_valid && !controller_enabled |=> cmd_reject && !cmd_accept; endproperty
	a_off: assert property (p_off) else $error("disabled command answered");
	property p_refuse; cmd_valid && controller_enabled && secured
		&& cmd.cmd_class inside {DSP_CMD_ACTIVE_ONLY, DSP_CMD_MEMORY} |=> cmd_reject; endproperty
	a_refuse: assert property (p_refuse) else $error("secured command ran");
	property p_grant; cmd_valid && controller_enabled && (!secured
		|| cmd.cmd_class inside {DSP_CMD_ALWAYS, DSP_CMD_MASS_ERASE}) |=> cmd_accept && !cmd_reject; endproperty
	a_grant: assert property (p_grant) else $error("allowed command refused");
	property p_wait; stop_handshake_busy && !stop_active
		&& (!bus_masters_idle || debug_access_busy) |=> !stop_active; endproperty
	a_wait: assert property (p_wait) else $error("stop entered while busy");
	property p_hold; stop_handshake_busy && !stop_active |-> clk_gate == 3'h7; endproperty
	a_hold: assert property (p_hold) else $error("clocks changed while pending");
	property p_cis0; $rose(stop_active) && controller_enabled && !debug_clocks_in_stop_bit
		|=> clk_gate == 3'h3; endproperty
	a_cis0: assert property (p_cis0) else $error("wrong stop gating");
	property p_gate_off; $rose(stop_active) && !controller_enabled |=> clk_gate == 3'h0; endproperty
	a_gate_off: assert property (p_gate_off) else $error("disabled stop gating");
	property p_ack; $fell(debug_access_busy) && bus_masters_idle && stop_handshake_busy && !stop_active
		&& controller_enabled |-> !stop_active [*4]; endproperty
	a_ack: assert property (p_ack) else $error("entry too short");
	property p_exit; stop_active && !stop_handshake_busy && wake_request && controller_enabled
		|=> stop_active [*4]; endproperty
	a_exit: assert property (p_exit) else $error("exit too short");
	c_acc: cover property (cmd_accept);
	c_rej: cover property (cmd_reject);
	c_stop: cover property ($rose(stop_active));
endmodule // dsp_top_chk

bind dsp_top dsp_top_chk u_chk (.clk, .reset, .secured, .debug_clocks_in_stop_bit, .controller_enabled,
	.cmd_valid, .cmd, .cmd_accept, .cmd_reject, .debug_access_busy, .bus_masters_idle, .wake_request, .stop_active,
	.stop_handshake_busy, .clk_gate);

// ===== tb/dsp_host_model.sv
// host side: serial-interface clock and clock-source select
// assumes clk is the bus clock; link clock stands still unless run
`timescale 1ns/1ps
module dsp_host_model (
	// bus clock
	input wire logic clk,
	// frame control
	input wire logic run,
	input wire logic [3:0] half,
	// link
	output logic si_clk,
	output logic src_sel
);
	logic [3:0] cnt;
	assign src_sel = 1'b0;
	initial si_clk = 1'b0;
	initial cnt = 4'h0;
	always @(posedge clk) begin
		if (!run || cnt == half)
			cnt <= 4'h0;
		else
			cnt <= cnt + 4'h1;
		// off the bus edge, toggled 5 ns after the clk edge
		if (run && cnt == half)
			si_clk <= #5 ~si_clk;
	end
endmodule // dsp_host_model

// ===== tb/tb.sv
// testbench: command gating and stop handshake of dsp_top
// assumes the host model supplies the serial clock
`timescale 1ns/1ps
module tb;
	import dsp_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	dsp_mode_type mode = DSP_MODE_NORMAL_SINGLE;
	logic secured = 1'b0;
	logic en = 1'b0;
	logic cis = 1'b0;
	logic cmd_valid = 1'b0;
	dsp_cmd_type cmd = '0;
	logic busy = 1'b0;
	logic stop_request = 1'b0;
	logic wake_request = 1'b0;
	logic idle = 1'b1;
	logic run = 1'b0;
	logic [3:0] half = 4'h3;
	logic css, si, cmd_accept, cmd_reject, stop_active, hs_busy, active, enabled, clock_ok;
	dsp_clk_gate_type gate;
	int errors = 0;
	int n_compared = 0;
	int nd, xd, ne, xe;
	always #12.5 clk = ~clk;
	dsp_top dut (.clk(clk), .reset(reset), .mode(mode), .secured(secured), .debug_enable_bit(en),
		.debug_clocks_in_stop_bit(cis), .debug_clock_source_select(css), .debug_serial_interface_clock(si),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
		.debug_access_busy(busy), .stop_request(stop_request), .wake_request(wake_request),
		.bus_masters_idle(idle), .stop_active(stop_active), .stop_handshake_busy(hs_busy), .clk_gate(gate),
		.active_debug_state(active), .controller_enabled(enabled), .debug_clock_ok(clock_ok));
	dsp_host_model host (.clk(clk), .run(run), .half(half), .si_clk(si), .src_sel(css));
	// ********
	// helpers
	// ********
	task tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task chk(input logic [3:0] s, input logic [3:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task final_report;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task start(input dsp_mode_type m, input logic s, input logic e);
		reset = 1'b1;
		mode = m;
		secured = s;
		en = e;
		tick(6);
		reset = 1'b0;
		tick(3);
	endtask
	// ********
	// scenarios
	// ********
	task t_cmds(input dsp_mode_type m, input logic s, input logic e);
		logic ok;
		start(m, s, 1'b0);
		chk({enabled, active}, {e, e});
		// back to back through every class
		cmd_valid = 1'b1;
		for (int c = 0; c < 4; c++) begin
			cmd = {c[1:0], 8'h5a};
			ok = e && (!s || c == 0 || c == 3);
			tick(1);
			chk({cmd_accept, cmd_reject}, {ok, !ok});
		end
		cmd_valid = 1'b0;
		tick(1);
	endtask
	task t_stop(input logic e, input logic c, input logic [2:0] g, output int n, output int x);
		cis = c;
		run = 1'b1;
		idle = 1'b0;
		busy = 1'b1;
		stop_request = 1'b1;
		tick(1);
		stop_request = 1'b0;
		tick(6);
		chk({stop_active, gate}, 4'h7);
		chk({hs_busy, enabled}, {1'b1, e});
		idle = 1'b1;
		tick(3);
		chk({stop_active, gate}, 4'h7);
		busy = 1'b0;
		n = 0;
		while (stop_active !== 1'b1 && n < 60) begin
			tick(1);
			n++;
		end
		tick(1);
		chk({stop_active, gate}, {1'b1, g});
		chk(clock_ok, 1'b1);
		// enabling from inside stop must not take
		en = 1'b1;
		tick(2);
		chk(enabled, e);
		wake_request = 1'b1;
		tick(1);
		wake_request = 1'b0;
		x = 0;
		while (stop_active !== 1'b0 && x < 60) begin
			tick(1);
			x++;
		end
		chk(stop_active, 1'b0);
		tick(1);
		chk(enabled, 1'b1);
		run = 1'b0;
		tick(2);
	endtask
	initial begin
		t_cmds(DSP_MODE_NORMAL_SINGLE, 1'b1, 1'b0);
		t_cmds(DSP_MODE_NORMAL_EXP, 1'b1, 1'b0);
		t_cmds(DSP_MODE_SPECIAL_SINGLE, 1'b0, 1'b1);
		t_cmds(DSP_MODE_SPECIAL_SINGLE, 1'b1, 1'b1);
		start(DSP_MODE_NORMAL_SINGLE, 1'b0, 1'b0);
		t_stop(1'b0, 1'b0, 3'h0, nd, xd);
		start(DSP_MODE_SPECIAL_SINGLE, 1'b0, 1'b0);
		t_stop(1'b1, 1'b0, 3'h3, ne, xe);
		chk({ne >= nd + 4, xe >= xd + 4}, 2'h3);
		half = 4'h1;
		t_stop(1'b1, 1'b1, 3'h7, ne, xe);
		final_report();
	end
	// cuts a hang short
	initial begin
		#100000;
		errors++;
		final_report();
	end
endmodule // tb
